// File: src/qrsp_ddr_out.sv
`timescale 1ns/1ns
`include "qrsp_map.svh"
module qrsp_ddr_out
#(
	parameter int WIDTH = 18
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_d_rise,
	input wire logic [WIDTH-1:0] i_d_fall,
	input wire logic i_oe_rise,
	output logic [WIDTH-1:0] o_q,
	output logic o_q_oe_b
);
	logic [WIDTH-1:0] rise_reg;
	logic [WIDTH-1:0] fall_reg;
	logic oe_b_reg;

	// word and drive enable launched on the positive output strobe
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rise_reg <= '0;
			oe_b_reg <= ~`QRSP_OE_RST;
		end
		else
		begin
			rise_reg <= i_d_rise; // [R10]
			oe_b_reg <= ~i_oe_rise; // [R11]
		end
	end

	// word launched on the negative output strobe
	always_ff @(negedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			fall_reg <= '0;
		else
			fall_reg <= i_d_fall; // [R10]
	end

	// output cell: rise word while strobe high, fall word while low
	assign o_q = i_clk ? rise_reg : fall_reg;
	assign o_q_oe_b = oe_b_reg; // active low straight from its flop
endmodule

// File: src/qrsp_map.svh
// How it works
// R1 - write data captured on rising edges of both capture strobes
// R2 - write port select sampled low on positive strobe starts a write
// R3 - write port select high: write data ignored for that slot
// R4 - byte lane selects sampled with each word; unselected lanes keep contents
// R5 - lane 0 covers bits 8:0, lane 1 17:9, lane 2 26:18, lane 3 35:27
// R6 - lane selects taken on the same edge as their data word
// R7 - one shared address bus sampled on the positive strobe
// R8 - storage is four arrays, one per burst word; 18 or 17 address bits
// R9 - address ignored when the slot's port select is inactive
// R10 - read data launched on both output strobes, or capture strobes in single mode
// R11 - read outputs three-stated while the read port is deselected
// R12 - read port select sampled low on positive strobe starts a read
// R13 - on deselect, pending burst ends, then outputs float after next output rise
// R14 - each read delivers four consecutive words
// R15 - operations begin only on a positive capture strobe rising edge
// R16 - negative capture strobe captures inputs and launches data in single mode
// R17 - read and write slots alternate on positive strobe edges
// R18 - controller gives four write words with lane selects back to back
`ifndef QRSP_MAP_SVH
`define QRSP_MAP_SVH

// ****************************************************
// geometry
// ****************************************************
`define QRSP_LANE_W 9
`define QRSP_BURST_LEN 4
`define QRSP_NARROW_DATA_W 18
`define QRSP_WIDE_DATA_W 36
`define QRSP_NARROW_ADDR_W 18
`define QRSP_WIDE_ADDR_W 17

// ****************************************************
// reset values
// ****************************************************
`define QRSP_SLOT_RD_RST 1'b1
`define QRSP_OE_RST 1'b0

`endif

// File: src/qrsp_pkg.sv
package qrsp_pkg;
	// write burst progress on positive strobe edges
	typedef enum logic [2:0]
	{
		WR_IDLE = 3'b001,
		WR_MID = 3'b010,
		WR_TAIL = 3'b100
	} qrsp_wr_state_t;

	// read output pair being launched
	typedef enum logic [2:0]
	{
		RD_HIZ = 3'b001,
		RD_HALF0 = 3'b010,
		RD_HALF1 = 3'b100
	} qrsp_rd_state_t;
endpackage

// File: src/qrsp_sync2.sv
`timescale 1ns/1ns
module qrsp_sync2
#(
	parameter int WIDTH = 1
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= i_d;
			sync_reg <= meta_reg;
		end
	end

	assign o_q = sync_reg;
endmodule

// File: src/qrsp_top.sv
`timescale 1ns/1ns
`include "qrsp_map.svh"
module qrsp_top
#(
	parameter bit WIDE = 1'b0
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_clk_k,
	input wire logic i_clk_c,
	input wire logic i_single_clk_mode,
	input wire logic i_write_port_select_n,
	input wire logic i_read_port_select_n,
	input wire logic [(WIDE ? `QRSP_WIDE_ADDR_W : `QRSP_NARROW_ADDR_W)-1:0] i_addr,
	input wire logic [(WIDE ? 4 : 2)-1:0] i_byte_lane_write_select_n,
	input wire logic [(WIDE ? `QRSP_WIDE_DATA_W : `QRSP_NARROW_DATA_W)-1:0] i_wdata,
	output logic [(WIDE ? `QRSP_WIDE_DATA_W : `QRSP_NARROW_DATA_W)-1:0] o_rdata,
	output logic o_rdata_oe_b,
	output logic o_wr_done,
	output logic o_rd_done
);
	localparam int DATA_W = WIDE ? `QRSP_WIDE_DATA_W : `QRSP_NARROW_DATA_W;
	localparam int ADDR_W = WIDE ? `QRSP_WIDE_ADDR_W : `QRSP_NARROW_ADDR_W;
	localparam int LANES = DATA_W / `QRSP_LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int NWORD = `QRSP_BURST_LEN;

	// ****************************************************
	// byte lane merge
	// ****************************************************
	function automatic logic [DATA_W-1:0] lane_merge
	(
		input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w,
		input logic [LANES-1:0] sel_n
	);
		logic [DATA_W-1:0] res;
		res = old_w;
		for (int l = 0; l < LANES; l++)
		begin
			if (!sel_n[l])
				res[l*`QRSP_LANE_W +: `QRSP_LANE_W] = new_w[l*`QRSP_LANE_W +: `QRSP_LANE_W];
		end
		return res;
	endfunction

	// ****************************************************
	// resets per domain
	// ****************************************************
	logic out_clk;
	logic k_rst_b;
	logic o_rst_b;

	// output strobe: capture strobe pair in single clock mode
	assign out_clk = i_single_clk_mode ? i_clk_k : i_clk_c; // [R10] [R16]

	qrsp_sync2 #(.WIDTH(1)) u_k_rst
	(
		.i_clk(i_clk_k),
		.i_rst_b(i_rst_b),
		.i_d(1'b1),
		.o_q(k_rst_b)
	);

	qrsp_sync2 #(.WIDTH(1)) u_o_rst
	(
		.i_clk(out_clk),
		.i_rst_b(i_rst_b),
		.i_d(1'b1),
		.o_q(o_rst_b)
	);

	// ****************************************************
	// capture strobe domain
	// ****************************************************
	logic slot_rd_reg;
	qrsp_pkg::qrsp_wr_state_t wr_state_reg;
	qrsp_pkg::qrsp_wr_state_t wr_state_next;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic rd_load_reg;
	logic rd_tog_reg;
	logic wr_tog_reg;
	logic [DATA_W-1:0] dn_reg;
	logic [LANES-1:0] bn_reg;
	logic [DATA_W-1:0] mem_reg [0:NWORD-1][0:DEPTH-1];
	logic [DATA_W-1:0] rd_buf_reg [0:NWORD-1];
	logic wr_take;
	logic rd_take;

	// a slot starts only on a positive strobe, in its own alternate slot
	assign wr_take = !slot_rd_reg && !i_write_port_select_n; // [R2] [R3] [R15]
	assign rd_take = slot_rd_reg && !i_read_port_select_n; // [R12] [R15]

	// read and write slots alternate
	always_ff @(posedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
			slot_rd_reg <= `QRSP_SLOT_RD_RST;
		else
			slot_rd_reg <= ~slot_rd_reg; // [R17]
	end

	// write burst sequencing
	always_comb
	begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			qrsp_pkg::WR_IDLE: wr_state_next = wr_take ? qrsp_pkg::WR_MID : qrsp_pkg::WR_IDLE;
			qrsp_pkg::WR_MID: wr_state_next = qrsp_pkg::WR_TAIL;
			qrsp_pkg::WR_TAIL: wr_state_next = wr_take ? qrsp_pkg::WR_MID : qrsp_pkg::WR_IDLE;
			default: wr_state_next = qrsp_pkg::WR_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
			wr_state_reg <= qrsp_pkg::WR_IDLE;
		else
			wr_state_reg <= wr_state_next; // [R18]
	end

	// address taken only for a selected slot
	always_ff @(posedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
		begin
			wr_addr_reg <= '0;
			rd_addr_reg <= '0;
		end
		else
		begin
			if (wr_take)
				wr_addr_reg <= i_addr; // [R7] [R9]
			if (rd_take)
				rd_addr_reg <= i_addr; // [R7] [R9]
		end
	end

	// negative strobe captures the odd words and their lane selects
	always_ff @(negedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
		begin
			dn_reg <= '0;
			bn_reg <= '1;
		end
		else
		begin
			dn_reg <= i_wdata; // [R1] [R16]
			bn_reg <= i_byte_lane_write_select_n; // [R6]
		end
	end

	// four arrays, one per burst word, lanes merged per word
	always_ff @(posedge i_clk_k)
	begin
		if (wr_take)
			mem_reg[0][i_addr] <= lane_merge(mem_reg[0][i_addr], i_wdata,
				i_byte_lane_write_select_n); // [R1] [R4] [R5] [R6] [R8]
		if (wr_state_reg == qrsp_pkg::WR_MID)
		begin
			mem_reg[1][wr_addr_reg] <= lane_merge(mem_reg[1][wr_addr_reg], dn_reg,
				bn_reg); // [R4] [R6]
			mem_reg[2][wr_addr_reg] <= lane_merge(mem_reg[2][wr_addr_reg], i_wdata,
				i_byte_lane_write_select_n); // [R4] [R6]
		end
		if (wr_state_reg == qrsp_pkg::WR_TAIL)
			mem_reg[3][wr_addr_reg] <= lane_merge(mem_reg[3][wr_addr_reg], dn_reg,
				bn_reg); // [R4] [R6]
	end

	// read: fetch all four words one edge after the address
	always_ff @(posedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
		begin
			rd_load_reg <= 1'b0;
			rd_tog_reg <= 1'b0;
			wr_tog_reg <= 1'b0;
			for (int w = 0; w < NWORD; w++)
				rd_buf_reg[w] <= '0;
		end
		else
		begin
			rd_load_reg <= rd_take;
			if (wr_take)
				wr_tog_reg <= ~wr_tog_reg;
			if (rd_load_reg)
			begin
				for (int w = 0; w < NWORD; w++)
					rd_buf_reg[w] <= mem_reg[w][rd_addr_reg]; // [R14]
				rd_tog_reg <= ~rd_tog_reg;
			end
		end
	end

	// ****************************************************
	// output strobe domain
	// ****************************************************
	logic seen_tog_reg;
	logic launch_tog_reg;
	logic launch_seen_reg;
	logic [DATA_W-1:0] out_buf_reg [0:NWORD-1];
	qrsp_pkg::qrsp_rd_state_t rd_state_reg;
	qrsp_pkg::qrsp_rd_state_t rd_state_next;
	logic start;
	logic [DATA_W-1:0] d_rise;
	logic [DATA_W-1:0] d_fall;
	logic oe_rise;

	// burst copied on a negative edge, half a cycle before launch
	always_ff @(negedge out_clk or negedge o_rst_b)
	begin
		if (!o_rst_b)
		begin
			seen_tog_reg <= 1'b0;
			launch_tog_reg <= 1'b0;
			for (int w = 0; w < NWORD; w++)
				out_buf_reg[w] <= '0;
		end
		else if (rd_tog_reg != seen_tog_reg)
		begin
			seen_tog_reg <= rd_tog_reg;
			launch_tog_reg <= ~launch_tog_reg;
			for (int w = 0; w < NWORD; w++)
				out_buf_reg[w] <= rd_buf_reg[w];
		end
	end

	assign start = launch_tog_reg != launch_seen_reg;

	// two rise/fall pairs, then float unless a new burst follows
	always_comb
	begin
		rd_state_next = rd_state_reg;
		case (rd_state_reg)
			qrsp_pkg::RD_HIZ: rd_state_next = start ? qrsp_pkg::RD_HALF0 : qrsp_pkg::RD_HIZ;
			qrsp_pkg::RD_HALF0: rd_state_next = qrsp_pkg::RD_HALF1; // [R14]
			qrsp_pkg::RD_HALF1: rd_state_next = start ? qrsp_pkg::RD_HALF0 : qrsp_pkg::RD_HIZ;
			default: rd_state_next = qrsp_pkg::RD_HIZ;
		endcase
	end

	always_ff @(posedge out_clk or negedge o_rst_b)
	begin
		if (!o_rst_b)
		begin
			rd_state_reg <= qrsp_pkg::RD_HIZ;
			launch_seen_reg <= 1'b0;
		end
		else
		begin
			rd_state_reg <= rd_state_next; // [R13]
			launch_seen_reg <= launch_tog_reg;
		end
	end

	// word selection for each output edge
	assign d_rise = start ? out_buf_reg[0] : out_buf_reg[2]; // [R10]
	assign d_fall = (rd_state_reg == qrsp_pkg::RD_HALF0) ? out_buf_reg[1] : out_buf_reg[3];
	assign oe_rise = start || (rd_state_reg == qrsp_pkg::RD_HALF0); // [R11] [R13]

	qrsp_ddr_out #(.WIDTH(DATA_W)) u_ddr_out
	(
		.i_clk(out_clk),
		.i_rst_b(o_rst_b),
		.i_d_rise(d_rise),
		.i_d_fall(d_fall),
		.i_oe_rise(oe_rise),
		.o_q(o_rdata),
		.o_q_oe_b(o_rdata_oe_b)
	);

	// ****************************************************
	// system clock status
	// ****************************************************
	logic [1:0] sys_tog;
	logic [1:0] sys_prev_reg;

	qrsp_sync2 #(.WIDTH(2)) u_stat_sync
	(
		.i_clk(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_d({rd_tog_reg, wr_tog_reg}),
		.o_q(sys_tog)
	);

	// toggle edges become one-cycle pulses
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sys_prev_reg <= '0;
			o_wr_done <= 1'b0;
			o_rd_done <= 1'b0;
		end
		else
		begin
			sys_prev_reg <= sys_tog;
			o_wr_done <= sys_tog[0] ^ sys_prev_reg[0];
			o_rd_done <= sys_tog[1] ^ sys_prev_reg[1];
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	logic chk_arm_reg;
	logic [ADDR_W-1:0] chk_addr_reg;
	logic [`QRSP_LANE_W-1:0] chk_old_reg;

	// lane 0 of word 0 remembered when its select is off
	always_ff @(posedge i_clk_k or negedge k_rst_b)
	begin
		if (!k_rst_b)
		begin
			chk_arm_reg <= 1'b0;
			chk_addr_reg <= '0;
			chk_old_reg <= '0;
		end
		else
		begin
			chk_arm_reg <= wr_take && i_byte_lane_write_select_n[0];
			chk_addr_reg <= i_addr;
			chk_old_reg <= mem_reg[0][i_addr][`QRSP_LANE_W-1:0];
		end
	end

	slot_alternate_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R17]
		k_rst_b |=> slot_rd_reg != $past(slot_rd_reg))
		else $error("slots did not alternate");

	wr_start_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R2]
		(!slot_rd_reg && !i_write_port_select_n) |=> wr_state_reg == qrsp_pkg::WR_MID
		##1 wr_state_reg == qrsp_pkg::WR_TAIL)
		else $error("write burst did not run");

	wr_ignore_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R3]
		(wr_state_reg != qrsp_pkg::WR_MID && (slot_rd_reg || i_write_port_select_n))
		|=> wr_state_reg != qrsp_pkg::WR_MID && $stable(wr_addr_reg))
		else $error("deselected write slot acted");

	lane_keep_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R4]
		chk_arm_reg |-> mem_reg[0][chk_addr_reg][`QRSP_LANE_W-1:0] == chk_old_reg)
		else $error("unselected lane changed");

	rd_addr_hold_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R9]
		!rd_take |=> $stable(rd_addr_reg))
		else $error("read address taken without a read");

	rd_start_a: assert property (@(posedge i_clk_k) disable iff (!k_rst_b) // [R12]
		rd_take |=> rd_load_reg ##1 rd_tog_reg != $past(rd_tog_reg))
		else $error("read did not fetch its burst");

	burst_pairs_a: assert property (@(posedge out_clk) disable iff (!o_rst_b) // [R14]
		rd_state_reg == qrsp_pkg::RD_HALF0 |=> rd_state_reg == qrsp_pkg::RD_HALF1
		&& !o_rdata_oe_b)
		else $error("burst cut short");

	hiz_after_a: assert property (@(posedge out_clk) disable iff (!o_rst_b) // [R13]
		(rd_state_reg == qrsp_pkg::RD_HALF1 && !start) |=> o_rdata_oe_b)
		else $error("outputs not floated after burst");
endmodule

// File: verification/qrsp_bench.sv
`timescale 1ns/1ns
`include "qrsp_map.svh"
module qrsp_bench;
	localparam int AW = `QRSP_WIDE_ADDR_W;
	localparam int DW = `QRSP_WIDE_DATA_W;
	logic i_clk_sys;
	logic i_rst_b;
	logic i_single_clk_mode;
	logic clk_k;
	logic clk_c;
	logic wps_n;
	logic rps_n;
	logic [AW-1:0] addr;
	logic [3:0] bws_n;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	logic rdata_oe_b;
	logic wr_done;
	logic rd_done;
	int mismatches = 0;
	int checks = 0;
	int wr_pulses = 0;
	int rd_pulses = 0;
	int wr_exp = 0;
	int rd_exp = 0;

	qrsp_top
	#(
		.WIDE(1'b1)
	)
	dut_u
	(
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_clk_k(clk_k),
		.i_clk_c(clk_c),
		.i_single_clk_mode(i_single_clk_mode),
		.i_write_port_select_n(wps_n),
		.i_read_port_select_n(rps_n),
		.i_addr(addr),
		.i_byte_lane_write_select_n(bws_n),
		.i_wdata(wdata),
		.o_rdata(rdata),
		.o_rdata_oe_b(rdata_oe_b),
		.o_wr_done(wr_done),
		.o_rd_done(rd_done)
	);

	qrsp_ctrl_model
	#(
		.AW(AW),
		.DW(DW),
		.LN(4)
	)
	u_ctrl
	(
		.i_rst_b(i_rst_b),
		.i_rdata(rdata),
		.i_rdata_oe_b(rdata_oe_b),
		.o_clk_k(clk_k),
		.o_clk_c(clk_c),
		.o_write_port_select_n(wps_n),
		.o_read_port_select_n(rps_n),
		.o_addr(addr),
		.o_byte_lane_write_select_n(bws_n),
		.o_wdata(wdata)
	);

	// ****
	// clock, pulse counters, helpers
	// ****
	// status clock
	initial
	begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	// count done pulses
	always @(posedge i_clk_sys)
	begin
		if (wr_done === 1'b1)
			wr_pulses++;
		if (rd_done === 1'b1)
			rd_pulses++;
	end

	task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] seen);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset(input logic mode);
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		i_single_clk_mode <= mode;
		u_ctrl.park_c <= mode;
		repeat (2) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
	endtask

	function automatic logic [DW-1:0] pat(input logic [AW-1:0] a, input int k);
		pat = {k[1:0], a[15:0], ~k[1:0], 16'hC35A};
	endfunction

	// ****
	// scenarios
	// ****
	// full write then read back, outputs float after the burst
	task automatic sc_full(input logic [AW-1:0] a, input int idle);
		logic [DW-1:0] w [4];
		logic [3:0] b [4];
		logic [DW-1:0] q [8];
		logic [8:0] oe;
		for (int k = 0; k < 4; k++)
		begin
			w[k] = pat(a, k);
			b[k] = 4'h0;
		end
		u_ctrl.write_burst(a, w, b, 1'b0, idle);
		wr_exp++;
		u_ctrl.read_run(a, a, 1, 1'b0, q, oe);
		rd_exp++;
		for (int k = 0; k < 4; k++)
			chk("read word", w[k], q[k]);
		chk("drive enable", 36'h0_0000_01F0, DW'(oe));
	endtask

	// word k writes only lane (k + 1) mod 4
	task automatic sc_lanes(input logic [AW-1:0] a);
		logic [DW-1:0] w [4];
		logic [DW-1:0] e [4];
		logic [3:0] b [4];
		logic [DW-1:0] q [8];
		logic [8:0] oe;
		sc_full(a, 0);
		for (int k = 0; k < 4; k++)
		begin
			w[k] = ~pat(a, k);
			b[k] = ~(4'h1 << ((k + 1) % 4));
			e[k] = pat(a, k);
			e[k][9*((k + 1) % 4) +: 9] = w[k][9*((k + 1) % 4) +: 9];
		end
		u_ctrl.write_burst(a, w, b, 1'b0, 0);
		wr_exp++;
		u_ctrl.read_run(a, a, 1, 1'b0, q, oe);
		rd_exp++;
		for (int k = 0; k < 4; k++)
			chk("lane merge", e[k], q[k]);
	endtask

	// deselected slots leave memory and outputs alone
	task automatic sc_deselect(input logic [AW-1:0] a);
		logic [DW-1:0] w [4];
		logic [3:0] b [4];
		logic [DW-1:0] q [8];
		logic [8:0] oe;
		sc_full(a, 1);
		for (int k = 0; k < 4; k++)
		begin
			w[k] = ~pat(a, k);
			b[k] = 4'h0;
		end
		u_ctrl.write_burst(a, w, b, 1'b1, 0);
		u_ctrl.read_run(a, a, 1, 1'b1, q, oe);
		chk("idle enable", 36'h0_0000_01FF, DW'(oe));
		u_ctrl.read_run(a, a, 1, 1'b0, q, oe);
		rd_exp++;
		for (int k = 0; k < 4; k++)
			chk("kept word", pat(a, k), q[k]);
	endtask

	// reads in successive read slots keep outputs driven
	task automatic sc_b2b(input logic [AW-1:0] a0, input logic [AW-1:0] a1);
		logic [DW-1:0] q [8];
		logic [8:0] oe;
		sc_full(a0, 0);
		sc_full(a1, 0);
		u_ctrl.read_run(a0, a1, 2, 1'b0, q, oe);
		rd_exp += 2;
		for (int k = 0; k < 4; k++)
		begin
			chk("first burst", pat(a0, k), q[k]);
			chk("second burst", pat(a1, k), q[k + 4]);
		end
		chk("joined enable", 36'h0_0000_0100, DW'(oe));
	endtask

	// ****
	// main sequence
	// ****
	initial
	begin
		i_rst_b = 1'b0;
		i_single_clk_mode = 1'b0;
		do_reset(1'b0);
		sc_full(17'h0_0123, 0);
		sc_lanes(17'h0_0456);
		sc_deselect(17'h0_0789);
		sc_b2b(17'h0_0000, 17'h1_FFFF);
		do_reset(1'b1);
		sc_full(17'h1_0F0F, 0);
		repeat (20) @(posedge i_clk_sys);
		chk("write pulses", DW'(wr_exp), DW'(wr_pulses));
		chk("read pulses", DW'(rd_exp), DW'(rd_pulses));
		chk("slot search", 36'h0_0000_0000, DW'(u_ctrl.slot_misses));
		end_of_test();
	end

	// hang guard
	initial
	begin
		repeat (30000) @(posedge i_clk_sys);
		mismatches++;
		$display("MISMATCH run length expected end seen hang");
		end_of_test();
	end
endmodule

// File: verification/qrsp_ctrl_model.sv
`timescale 1ns/1ns
module qrsp_ctrl_model
#(
	parameter int AW = 17,
	parameter int DW = 36,
	parameter int LN = 4
)
(
	input wire logic i_rst_b,
	input wire logic [DW-1:0] i_rdata,
	input wire logic i_rdata_oe_b,
	output logic o_clk_k,
	output logic o_clk_c,
	output logic o_write_port_select_n,
	output logic o_read_port_select_n,
	output logic [AW-1:0] o_addr,
	output logic [LN-1:0] o_byte_lane_write_select_n,
	output logic [DW-1:0] o_wdata
);
	int kcnt;
	int slot_misses = 0;
	bit park_c = 1'b0;

	// ****
	// strobes
	// ****
	// capture strobe runs free, slots alternate on it
	initial
	begin
		o_clk_k = 1'b0;
		o_clk_c = 1'b0;
		o_write_port_select_n = 1'b1;
		o_read_port_select_n = 1'b1;
		o_addr = {AW{1'b0}};
		o_byte_lane_write_select_n = {LN{1'b1}};
		o_wdata = {DW{1'b0}};
		forever #40 o_clk_k = ~o_clk_k;
	end

	// output strobe lags by an eighth period, parked low in single clock mode
	always @(o_clk_k) o_clk_c <= #10 (o_clk_k && !park_c);

	// capture rises since reset release
	always @(posedge o_clk_k or negedge i_rst_b)
		if (!i_rst_b)
			kcnt <= 0;
		else
			kcnt <= kcnt + 1;

	// ****
	// transfers
	// ****
	// stop just after the rise before the wanted slot
	task automatic wait_slot(input bit rd, input int idle);
		int n;
		n = 0;
		repeat (2 * idle) @(posedge o_clk_k);
		@(posedge o_clk_k);
		#1;
		while (n < 4 && !(kcnt >= 2 && (kcnt % 2) == (rd ? 0 : 1)))
		begin
			@(posedge o_clk_k);
			#1;
			n++;
		end
		if (n == 4)
			slot_misses++;
	endtask

	// four words back to back, lane selects with each word
	task automatic write_burst(input logic [AW-1:0] addr, input logic [DW-1:0] w [4],
		input logic [LN-1:0] b [4], input bit sel_n, input int idle);
		wait_slot(1'b0, idle);
		o_write_port_select_n = sel_n;
		o_addr = addr;
		o_wdata = w[0];
		o_byte_lane_write_select_n = b[0];
		for (int i = 1; i < 4; i++)
		begin
			if (i % 2)
				@(posedge o_clk_k);
			else
				@(negedge o_clk_k);
			#1;
			o_write_port_select_n = 1'b1;
			if (i == 1)
				o_addr = ~o_addr;
			o_wdata = w[i];
			o_byte_lane_write_select_n = b[i];
		end
		@(negedge o_clk_k);
		#1;
		o_wdata = ~o_wdata;
		o_byte_lane_write_select_n = ~o_byte_lane_write_select_n;
	endtask

	// one or two reads in successive read slots, eight samples then one more
	task automatic read_run(input logic [AW-1:0] a0, input logic [AW-1:0] a1, input int n,
		input bit sel_n, output logic [DW-1:0] q [8], output logic [8:0] oe);
		wait_slot(1'b1, 0);
		o_read_port_select_n = sel_n;
		o_addr = a0;
		@(posedge o_clk_k);
		#1;
		o_read_port_select_n = 1'b1;
		o_addr = ~o_addr;
		@(posedge o_clk_k);
		#1;
		if (n == 2)
		begin
			o_read_port_select_n = sel_n;
			o_addr = a1;
		end
		@(posedge o_clk_k);
		#1;
		o_read_port_select_n = 1'b1;
		o_addr = ~o_addr;
		#19;
		for (int i = 0; i < 8; i++)
		begin
			q[i] = i_rdata;
			oe[i] = i_rdata_oe_b;
			#40;
		end
		oe[8] = i_rdata_oe_b;
	endtask
endmodule
